// ---- rtl/parpm_pkg.sv ----
// Constants and types shared by the request port map block
package parpm_pkg;
  localparam int PARPM_AW = 16;
  localparam int PARPM_PORTS = 8;
  localparam int PARPM_SRCS = 5;
  localparam int PARPM_SEL_W = 3;
  localparam int PARPM_FIELD_STRIDE = 4;
  localparam logic [15:0] PARPM_MAP_OFS = 16'hd100;
  localparam logic [15:0] PARPM_CFG_OFS = 16'hd104;
  localparam logic [15:0] PARPM_STAT_OFS = 16'hd108;
  localparam logic [15:0] PARPM_BROKEN_OFS = 16'hd110;
  localparam logic [31:0] PARPM_MAP_RST = 32'h7654_3210;
  localparam logic [31:0] PARPM_MAP_MASK = 32'h7777_7777;
  localparam int PARPM_CFG_CHECK_BIT = 0;
  localparam int PARPM_CFG_ENABLE_BIT = 1;
  localparam int PARPM_STAT_ANY_BIT = 0;
  localparam int PARPM_STAT_STALE_BIT = 1;
  localparam int PARPM_CTRL_SRC = 4;
  localparam logic [2:0] PARPM_CTRL_CODE = 3'h7;
  typedef logic [PARPM_PORTS-1:0][PARPM_SEL_W-1:0] parpm_sel_t;
endpackage : parpm_pkg

// ---- rtl/parpm_route_if.sv ----
// Signals between the register side and the routing decoder
`timescale 1ns/1ns
interface parpm_route_if;
  import parpm_pkg::*;
  parpm_sel_t sel;
  logic [PARPM_SRCS-1:0] src_req;
  logic [PARPM_PORTS-1:0] port_gnt;
  logic [PARPM_PORTS-1:0] port_req;
  logic [PARPM_SRCS-1:0] src_gnt;
  modport regs (output sel, src_req, port_gnt, input port_req, src_gnt);
  modport dec (input sel, src_req, port_gnt, output port_req, src_gnt);
endinterface : parpm_route_if

// ---- rtl/parpm_decode.sv ----
// Selector decode: sources onto ports, port grants back onto sources
`timescale 1ns/1ns
module parpm_decode
  import parpm_pkg::*;
(
  // Routing group
  parpm_route_if.dec rt
);
  logic [PARPM_PORTS-1:0][PARPM_SRCS-1:0] hit;
  logic [PARPM_SRCS-1:0][PARPM_PORTS-1:0] hit_t;

  genvar p, s;
  generate
    for (p = 0; p < PARPM_PORTS; p++) begin : g_port
      for (s = 0; s < PARPM_SRCS; s++) begin : g_src
        // Reserved codes 100..110 match no source
        localparam logic [2:0] CODE = (s == PARPM_CTRL_SRC) ?
          PARPM_CTRL_CODE : 3'(s);
        assign hit[p][s] = (rt.sel[p] == CODE);
        assign hit_t[s][p] = hit[p][s];
      end
      assign rt.port_req[p] = |(hit[p] & rt.src_req);
    end
    for (s = 0; s < PARPM_SRCS; s++) begin : g_gnt
      assign rt.src_gnt[s] = |(hit_t[s] & rt.port_gnt);
    end
  endgenerate
endmodule : parpm_decode

// ---- rtl/parpm_top.sv ----
// Request port map of the on-chip bus arbiter with its register port
//
// Behaviour
// - Each port A-D, W-Z is tied to at most one source: controller or line 0-3.
// - Code 111 picks the controller, codes 000-011 pick lines 0-3.
// - Codes 100, 101 and 110 leave the port with no requester.
// - A mapping change makes the held broken-requester bitmap invalid.
// - The mapping acts only while the on-chip arbiter is in use.
// - Selectors sit at 30:28 down to 2:0, bits 31, 27, ..., 3 reserved.
// - Reset loads A=111, B=110, C=101, D=100, W=011, X=010, Y=001, Z=000.
// - Software clears the bitmap to zero after changing the mapping.
// - External requests are refused until the arbiter enable bit is 1.
// - A 1 in a bitmap bit removes that port's master from arbitration.
`timescale 1ns/1ns
module parpm_top
  import parpm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [PARPM_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Request sources
  input wire logic ctrl_req,
  input wire logic [3:0] ext_req_n,
  input wire logic internal_arb_sel,
  output logic ctrl_gnt,
  output logic [3:0] ext_gnt_n,
  // Arbitration core
  output logic [PARPM_PORTS-1:0] port_req,
  input wire logic [PARPM_PORTS-1:0] port_gnt,
  input wire logic [PARPM_PORTS-1:0] broken_set
);
  logic [31:0] map_r, map_nxt;
  logic enable_r, enable_nxt;
  logic check_en_r, check_en_nxt;
  logic [PARPM_PORTS-1:0] bitmap_r, bitmap_nxt;
  logic stale_r, stale_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [PARPM_PORTS-1:0] port_req_r, port_req_nxt;
  logic ctrl_gnt_r, ctrl_gnt_nxt;
  logic [3:0] ext_gnt_n_r, ext_gnt_n_nxt;
  logic [3:0] ext_meta_r, ext_sync_r;
  logic int_meta_r, int_sync_r;
  logic map_wr;

  parpm_route_if rt ();

  parpm_decode u_decode (
    .rt(rt.dec)
  );

  genvar p;
  generate
    for (p = 0; p < PARPM_PORTS; p++) begin : g_sel
      assign rt.sel[p] = map_r[p*PARPM_FIELD_STRIDE +: PARPM_SEL_W];
    end
  endgenerate

  // The selector fields must tile the 32-bit map word without overlap
  if (PARPM_PORTS * PARPM_FIELD_STRIDE != 32 ||
      PARPM_SEL_W >= PARPM_FIELD_STRIDE) begin : g_map_fit
    $error("selector fields do not fit the map word");
  end

  // External lines are active low; refused while the arbiter is off
  assign rt.src_req = {ctrl_req, ~ext_sync_r & {4{enable_r}}};
  // Removed masters lose any grant the core may still show
  assign rt.port_gnt = port_gnt & ~bitmap_r;
  assign map_wr = reg_wr && (reg_addr == PARPM_MAP_OFS);

  always_comb begin
    map_nxt = map_r;
    enable_nxt = enable_r;
    check_en_nxt = check_en_r;
    bitmap_nxt = bitmap_r;
    stale_nxt = stale_r;
    rdata_nxt = 32'h0000_0000;
    if (map_wr) begin
      map_nxt = reg_wdata & PARPM_MAP_MASK;
      if ((reg_wdata & PARPM_MAP_MASK) != map_r) begin
        stale_nxt = 1'b1;
      end
    end
    if (reg_wr && (reg_addr == PARPM_CFG_OFS)) begin
      enable_nxt = reg_wdata[PARPM_CFG_ENABLE_BIT];
      check_en_nxt = reg_wdata[PARPM_CFG_CHECK_BIT];
    end
    if (reg_wr && (reg_addr == PARPM_BROKEN_OFS)) begin
      bitmap_nxt = reg_wdata[PARPM_PORTS-1:0];
      stale_nxt = 1'b0;
    end
    // Detection beats a software clear in the same cycle
    bitmap_nxt = bitmap_nxt | (broken_set & {PARPM_PORTS{check_en_r}});
    if (reg_rd) begin
      case (reg_addr)
        PARPM_MAP_OFS: rdata_nxt = map_r;
        PARPM_CFG_OFS: begin
          rdata_nxt[PARPM_CFG_ENABLE_BIT] = enable_r;
          rdata_nxt[PARPM_CFG_CHECK_BIT] = check_en_r;
        end
        PARPM_STAT_OFS: begin
          rdata_nxt[PARPM_STAT_STALE_BIT] = stale_r;
          rdata_nxt[PARPM_STAT_ANY_BIT] = |bitmap_r;
        end
        PARPM_BROKEN_OFS: rdata_nxt[PARPM_PORTS-1:0] = bitmap_r;
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    // With an outside arbiter the map is bypassed and all stays idle
    port_req_nxt = rt.port_req & ~bitmap_r & {PARPM_PORTS{int_sync_r}};
    ctrl_gnt_nxt = int_sync_r & rt.src_gnt[PARPM_CTRL_SRC];
    ext_gnt_n_nxt = ~(rt.src_gnt[3:0] & {4{int_sync_r & enable_r}});
  end

  always_ff @(posedge ref_clk) begin
    ext_meta_r <= ext_req_n;
    ext_sync_r <= ext_meta_r;
    int_meta_r <= internal_arb_sel;
    int_sync_r <= int_meta_r;
    if (!rst_n) begin
      map_r <= PARPM_MAP_RST;
      enable_r <= 1'b0;
      check_en_r <= 1'b0;
      bitmap_r <= '0;
      stale_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      port_req_r <= '0;
      ctrl_gnt_r <= 1'b0;
      ext_gnt_n_r <= 4'hf;
    end else begin
      map_r <= map_nxt;
      enable_r <= enable_nxt;
      check_en_r <= check_en_nxt;
      bitmap_r <= bitmap_nxt;
      stale_r <= stale_nxt;
      rdata_r <= rdata_nxt;
      port_req_r <= port_req_nxt;
      ctrl_gnt_r <= ctrl_gnt_nxt;
      ext_gnt_n_r <= ext_gnt_n_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign port_req = port_req_r;
  assign ctrl_gnt = ctrl_gnt_r;
  assign ext_gnt_n = ext_gnt_n_r;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  map_reset_a: assert property (
    !$past(rst_n) |-> map_r == PARPM_MAP_RST)
    else $error("map register not at its reset value");
  idle_reset_a: assert property (
    !$past(rst_n) |->
    port_req_r == '0 && !ctrl_gnt_r && ext_gnt_n_r == 4'hf)
    else $error("outputs not idle after reset");
  map_read_a: assert property (
    reg_rd && reg_addr == PARPM_MAP_OFS |=>
    reg_rdata == $past(map_r) && (reg_rdata & ~PARPM_MAP_MASK) == 0)
    else $error("map readback wrong");
  read_idle_a: assert property (
    !reg_rd |=> reg_rdata == '0)
    else $error("read data outside a read cycle");
  map_write_a: assert property (
    map_wr |=> map_r == ($past(reg_wdata) & PARPM_MAP_MASK))
    else $error("map write not stored");
  reserved_code_a: assert property (
    map_r[2] && map_r[2:0] != 3'h7 |=> !port_req_r[0])
    else $error("reserved selector drove a request");
  ctrl_route_a: assert property (
    map_r[30:28] == 3'h7 && int_sync_r && ctrl_req && !bitmap_r[7]
    |=> port_req_r[7])
    else $error("controller request not on port A");
  ext_route_a: assert property (
    map_r[14:12] == 3'h3 && enable_r && int_sync_r && !ext_sync_r[3] &&
    !bitmap_r[3] |=> port_req_r[3])
    else $error("line 3 request not on port W");
  ext_refused_a: assert property (
    !enable_r && map_r[2:0] == 3'h0 |=> !port_req_r[0])
    else $error("external request passed while disabled");
  ext_gnt_off_a: assert property (
    !enable_r |=> ext_gnt_n_r == 4'hf)
    else $error("external grant while disabled");
  cfg_read_a: assert property (
    reg_rd && reg_addr == PARPM_CFG_OFS |=>
    reg_rdata[PARPM_CFG_ENABLE_BIT] == $past(enable_r))
    else $error("enable bit readback wrong");
  outside_arb_a: assert property (
    !int_sync_r |=>
    port_req_r == '0 && !ctrl_gnt_r && ext_gnt_n_r == 4'hf)
    else $error("map active with outside arbiter");
  removed_a: assert property (
    bitmap_r[7] |=> !port_req_r[7])
    else $error("removed master still requesting");
  stale_flag_a: assert property (
    map_wr && (reg_wdata & PARPM_MAP_MASK) != map_r |=> stale_r)
    else $error("map change did not mark bitmap stale");
  stale_clear_a: assert property (
    reg_wr && reg_addr == PARPM_BROKEN_OFS |=> !stale_r)
    else $error("bitmap write did not clear stale flag");
  grant_route_a: assert property (
    map_r[30:28] == 3'h7 && port_gnt[7] && int_sync_r && !bitmap_r[7]
    |=> ctrl_gnt_r)
    else $error("port A grant not returned to controller");
  set_wins_a: assert property (
    check_en_r && broken_set[0] |=> bitmap_r[0])
    else $error("broken detection lost");
  check_off_a: assert property (
    !check_en_r && !(reg_wr && reg_addr == PARPM_BROKEN_OFS) |=>
    bitmap_r == $past(bitmap_r))
    else $error("bitmap changed with checking off");
  bitmap_write_a: assert property (
    reg_wr && reg_addr == PARPM_BROKEN_OFS && !check_en_r |=>
    bitmap_r == $past(reg_wdata[PARPM_PORTS-1:0]))
    else $error("bitmap write not stored");
  stat_read_a: assert property (
    reg_rd && reg_addr == PARPM_STAT_OFS |=>
    reg_rdata[PARPM_STAT_ANY_BIT] == |$past(bitmap_r))
    else $error("status summary bit wrong");
endmodule : parpm_top

// ---- bench/parpm_core_model.sv ----
// Arbitration core stand-in: grants the lowest requesting port
`timescale 1ns/1ns
module parpm_core_model
  import parpm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Port handshake
  input wire logic [PARPM_PORTS-1:0] port_req,
  output logic [PARPM_PORTS-1:0] port_gnt
);
  logic [PARPM_PORTS-1:0] gnt_nxt;
  // One-hot grant, so a grant never reaches two sources at once
  always_comb begin
    gnt_nxt = port_req & (~port_req + 8'h01);
  end
  always_ff @(posedge ref_clk) begin
    port_gnt <= rst_n ? gnt_nxt : 8'h00;
  end
endmodule : parpm_core_model

// ---- bench/parpm_top_tb.sv ----
// Self-checking bench for the request port map
`timescale 1ns/1ns
module parpm_top_tb;
  import parpm_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ctrl_req = 1'b0;
  logic [3:0] ext_req_n = 4'hf;
  logic internal_arb_sel = 1'b1;
  logic [7:0] broken_set = 8'h00;
  logic [31:0] reg_rdata;
  logic ctrl_gnt;
  logic [3:0] ext_gnt_n;
  logic [7:0] port_req;
  logic [7:0] port_gnt;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  parpm_top u_parpm_top (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ctrl_req, .ext_req_n, .internal_arb_sel,
    .ctrl_gnt, .ext_gnt_n, .port_req, .port_gnt, .broken_set);
  parpm_core_model u_parpm_core_model (.ref_clk, .rst_n, .port_req,
    .port_gnt);
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s exp %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(string n, logic [15:0] a, logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    // Data stand one cycle only; sample them at that cycle's closing edge
    @(posedge ref_clk);
    chk(n, reg_rdata, e);
  endtask : rd_chk
  // Covers the two-flop request path plus the grant turnaround
  task automatic settle();
    repeat (7) @(posedge ref_clk);
  endtask : settle
  task automatic t_disabled();
    rd_chk("map", PARPM_MAP_OFS, 32'h7654_3210);
    rd_chk("gap", 16'hd0fc, 32'h0);
    ext_req_n <= 4'h0;
    ctrl_req <= 1'b1;
    settle();
    chk("req", port_req, 8'h80);
    chk("cgnt", ctrl_gnt, 1'b1);
    chk("egnt", ext_gnt_n, 4'hf);
  endtask : t_disabled
  task automatic t_lines();
    wr(PARPM_CFG_OFS, 32'h2);
    ctrl_req <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      ext_req_n <= ~(4'h1 << k);
      settle();
      chk("req", port_req, 8'h01 << k);
      chk("egnt", ext_gnt_n, 4'(~(4'h1 << k)));
    end
  endtask : t_lines
  task automatic t_remap();
    wr(PARPM_MAP_OFS, 32'hc856_7456);
    rd_chk("map", PARPM_MAP_OFS, 32'h4056_7456);
    rd_chk("stat", PARPM_STAT_OFS, 32'h2);
    ext_req_n <= 4'he;
    ctrl_req <= 1'b1;
    settle();
    chk("req", port_req, 8'h48);
    chk("cgnt", ctrl_gnt, 1'b1);
    ext_req_n <= 4'hd;
    ctrl_req <= 1'b0;
    settle();
    chk("req", port_req, 8'h00);
    chk("egnt", ext_gnt_n, 4'hf);
    wr(PARPM_BROKEN_OFS, 32'h0);
    rd_chk("stat", PARPM_STAT_OFS, 32'h0);
  endtask : t_remap
  task automatic t_broken();
    ext_req_n <= 4'he;
    ctrl_req <= 1'b1;
    wr(PARPM_BROKEN_OFS, 32'h8);
    settle();
    chk("req", port_req, 8'h40);
    chk("egnt", ext_gnt_n, 4'he);
    rd_chk("stat", PARPM_STAT_OFS, 32'h1);
    internal_arb_sel <= 1'b0;
    settle();
    chk("req", port_req, 8'h00);
    chk("egnt", ext_gnt_n, 4'hf);
  endtask : t_broken
  // Detection is ignored with checking off; a detect beats a same-cycle clear
  task automatic t_detect();
    broken_set <= 8'h10;
    @(posedge ref_clk);
    broken_set <= 8'h00;
    rd_chk("bm", PARPM_BROKEN_OFS, 32'h08);
    wr(PARPM_CFG_OFS, 32'h3);
    broken_set <= 8'h04;
    @(posedge ref_clk);
    broken_set <= 8'h00;
    rd_chk("bm", PARPM_BROKEN_OFS, 32'h0c);
    @(posedge ref_clk);
    reg_addr <= PARPM_BROKEN_OFS;
    reg_wdata <= 32'h0;
    reg_wr <= 1'b1;
    broken_set <= 8'h01;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    broken_set <= 8'h00;
    rd_chk("bm", PARPM_BROKEN_OFS, 32'h01);
    rd_chk("cfg", PARPM_CFG_OFS, 32'h3);
  endtask : t_detect
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_disabled();
    t_lines();
    t_remap();
    t_broken();
    t_detect();
    end_of_test();
  end
  // A hang is cut short well past the 130 or so cycles the run needs
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      end_of_test();
    end
  end
endmodule : parpm_top_tb
